// ### core/dual_core_power_control.sv
// Top of the two-core power sequencer; the request strobes come from
// the host register path on this clock, core status from the cores.
`timescale 1ns/10ps
module dual_core_power_control #(
	parameter int NUM_CORES = pwr_pkg::NUM_CORES
) (
	input  wire logic                 clock,
	input  wire logic                 nrst,
	input  wire logic [NUM_CORES-1:0] pu_wr,
	input  wire logic [NUM_CORES-1:0] pu_wdata,
	input  wire logic [NUM_CORES-1:0] pd_wr,
	input  wire logic [NUM_CORES-1:0] pd_wdata,
	input  wire logic [NUM_CORES-1:0] core_idle_exec,
	input  wire logic [NUM_CORES-1:0] core_rti_exec,
	input  wire logic [NUM_CORES-1:0] ctx_select,
	input  wire logic                 mem_clk_stop_cfg,
	input  wire logic                 crystal_in_use,
	input  wire logic                 xtal_keep_running,
	input  wire logic                 host_mem_req,
	output logic      [NUM_CORES-1:0] power_up_request,
	output logic      [NUM_CORES-1:0] power_down_request,
	output logic      [NUM_CORES-1:0] pd_irq,
	output logic      [15:0]          pd_vector,
	output logic      [NUM_CORES-1:0] idle_fallthrough,
	output logic      [NUM_CORES-1:0] core_clk_en,
	output logic      [NUM_CORES-1:0] mem_clk_en,
	output logic      [NUM_CORES-1:0] resume_clear_ctx,
	output logic                      gen_enable,
	output logic                      gen_stable,
	output logic                      osc_enable,
	output logic                      host_mem_grant,
	output logic                      host_mem_refused
);
	// =========================================================
	// State
	typedef struct packed {
		logic [NUM_CORES-1:0]          pu;
		logic [NUM_CORES-1:0]          pd;
		logic [NUM_CORES-1:0]          irq;
		logic [NUM_CORES-1:0]          fall;
		logic [NUM_CORES-1:0]          cclk;
		logic [NUM_CORES-1:0]          mclk;
		logic [NUM_CORES-1:0]          ctx;
		logic [NUM_CORES-1:0]          was_down;
		logic                          gen_en;
		logic                          stable;
		logic [pwr_pkg::SETTLE_W-1:0]  settle;
		logic                          osc;
		logic                          grant;
		logic                          refuse;
	} top_s;

	top_s s_q;
	top_s s_d;

	logic [NUM_CORES-1:0] in_handler;
	logic [NUM_CORES-1:0] down;
	logic [NUM_CORES-1:0] take_irq;
	logic [NUM_CORES-1:0] fall;
	pwr_pkg::core_state_e cstate [NUM_CORES];

	// =========================================================
	// Per-core controllers
	genvar g;
	generate
		for (g = 0; g < NUM_CORES; g++) begin : g_core
			core_power_ctrl u_core (
				.clock              (clock),
				.nrst               (nrst),
				.power_up_request   (pu_wr[g] && pu_wdata[g]),
				.power_down_request (pd_wr[g] && pd_wdata[g]),
				.core_idle_exec     (core_idle_exec[g]),
				.core_rti_exec      (core_rti_exec[g]),
				.clk_stable         (s_q.stable),
				.mem_clk_stop_cfg   (mem_clk_stop_cfg),
				.in_handler         (in_handler[g]),
				.powered_down       (down[g]),
				.take_irq           (take_irq[g]),
				.idle_fallthrough   (fall[g]),
				.state              (cstate[g])
			);
		end
	endgenerate

	// =========================================================
	// Generator, clock gating and host access
	always_comb begin
		logic                 all_down;
		logic [NUM_CORES-1:0] core_asleep;
		logic                 waking;
		all_down    = 1'b1;
		core_asleep = '0;
		waking      = 1'b0;
		s_d         = s_q;
		for (int i = 0; i < NUM_CORES; i++) begin
			core_asleep[i] = (cstate[i] != pwr_pkg::CORE_RUN);
			all_down       = all_down && core_asleep[i];
			// Core clock gated off while asleep, memory clock too except in CORE_IDLE_MEMCLK; state is simply held
			s_d.cclk[i] = !core_asleep[i] && s_q.stable;
			s_d.mclk[i] = (cstate[i] == pwr_pkg::CORE_RUN)
				|| (cstate[i] == pwr_pkg::CORE_IDLE_MEMCLK);
			s_d.was_down[i] = core_asleep[i];
			// Latch context choice at the wake edge
			if (s_q.was_down[i] && !core_asleep[i]) begin
				s_d.ctx[i] = ctx_select[i];
			end
			waking = waking || (s_q.was_down[i] && !core_asleep[i]);
		end
		s_d.pu   = in_handler;
		s_d.pd   = down;
		s_d.irq  = take_irq;
		s_d.fall = fall;
		// Shared generator follows both cores
		s_d.gen_en = !all_down;
		if (!s_q.gen_en) begin
			s_d.stable = 1'b0;
			s_d.settle = '0;
		end else if (!s_q.stable) begin
			// Short settle keeps wake inside the recovery bound
			if (s_q.settle == pwr_pkg::SETTLE_W'(pwr_pkg::SETTLE_CYCLES - 1)) begin
				s_d.stable = 1'b1;
			end else begin
				s_d.settle = s_q.settle + 1'b1;
			end
		end
		// Crystal stops only when allowed and chosen
		s_d.osc = !(all_down && crystal_in_use && !xtal_keep_running);
		// Block host while generator off or unsettled
		s_d.grant  = host_mem_req && s_q.gen_en && s_q.stable && !waking;
		s_d.refuse = host_mem_req && !(s_q.gen_en && s_q.stable && !waking);
	end

	// Register the whole state
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_q        <= '0;
			s_q.gen_en <= 1'b1;
			s_q.osc    <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// Controls visible per core and shared
	assign power_up_request   = s_q.pu;
	assign power_down_request = s_q.pd;
	assign pd_irq             = s_q.irq;
	assign pd_vector          = pwr_pkg::PD_VECTOR;
	assign idle_fallthrough   = s_q.fall;
	assign core_clk_en        = s_q.cclk;
	assign mem_clk_en         = s_q.mclk;
	assign resume_clear_ctx   = s_q.ctx;
	assign gen_enable         = s_q.gen_en;
	assign gen_stable         = s_q.stable;
	assign osc_enable         = s_q.osc;
	assign host_mem_grant     = s_q.grant;
	assign host_mem_refused   = s_q.refuse;
endmodule // dual_core_power_control

// ### shared/pwr_pkg.sv
// Constants and types for the dual core power sequencer.
// Assumes a single 50 MHz core clock domain.
package pwr_pkg;
	localparam int          NUM_CORES        = 2;
	localparam int          CLK_PERIOD_NS    = 20;
	// Longest recovery allowed, in crystal cycles
	localparam int          RECOVERY_MAX_XTAL = 100;
	// Generator restart settle time, kept well inside the recovery bound
	localparam int          SETTLE_CYCLES    = 64;
	localparam int          SETTLE_W         = 7;
	// Entry delay after idle: one cycle
	localparam int          ENTRY_CYCLES_MIN = 1;
	localparam logic [15:0] PD_VECTOR        = 16'h0004;
	// Resume context choices
	localparam logic        CTX_RESUME       = 1'b0;
	localparam logic        CTX_CLEAR        = 1'b1;

	typedef enum logic [1:0] {
		CORE_RUN,
		CORE_IDLE_MEMCLK,
		CORE_IDLE_NOCLK,
		CORE_DOWN
	} core_state_e;
endpackage

// ### core/core_power_ctrl.sv
// One core's power-up/power-down control state.
// Assumes request pulses and status from the core on the same clock.
`timescale 1ns/10ps
module core_power_ctrl (
	input  wire logic        clock,
	input  wire logic        nrst,
	input  wire logic        power_up_request,
	input  wire logic        power_down_request,
	input  wire logic        core_idle_exec,
	input  wire logic        core_rti_exec,
	input  wire logic        clk_stable,
	input  wire logic        mem_clk_stop_cfg,
	output logic             in_handler,
	output logic             powered_down,
	output logic             take_irq,
	output logic             idle_fallthrough,
	output pwr_pkg::core_state_e state
);
	typedef struct packed {
		pwr_pkg::core_state_e st;
		logic                 handler;
		logic                 abort_pd;
		logic                 reenter;
		logic                 entering;
		logic                 irq;
		logic                 fall;
	} cstate_s;

	cstate_s s_q;
	cstate_s s_d;

	// =========================================================
	// Next state
	always_comb begin
		s_d      = s_q;
		s_d.irq  = 1'b0;
		s_d.fall = 1'b0;
		// Writing 0 reaches here as no pulse, so nothing changes
		if (power_down_request && !s_q.handler) begin
			s_d.handler  = 1'b1;
			s_d.irq      = 1'b1;
			s_d.abort_pd = 1'b0;
		end
		if (power_down_request && s_q.st != pwr_pkg::CORE_RUN) begin
			s_d.reenter = 1'b1;
		end
		if (s_q.handler && core_idle_exec && s_q.st == pwr_pkg::CORE_RUN) begin
			if (s_q.abort_pd) begin
				s_d.fall     = 1'b1;
				s_d.abort_pd = 1'b0;
			end else begin
				s_d.entering = 1'b1;
			end
		end
		if (s_q.entering) begin
			s_d.entering = 1'b0;
			// Memory clocks optionally left running
			s_d.st = mem_clk_stop_cfg ? pwr_pkg::CORE_DOWN : pwr_pkg::CORE_IDLE_MEMCLK;
		end
		if (power_up_request && s_q.handler) begin
			if (s_q.st != pwr_pkg::CORE_RUN || s_q.entering) begin
				s_d.st       = pwr_pkg::CORE_RUN;
				s_d.entering = 1'b0;
			end else begin
				s_d.abort_pd = 1'b1;
			end
		end
		if (s_q.handler && core_rti_exec && s_q.st == pwr_pkg::CORE_RUN) begin
			s_d.handler = s_q.reenter;
			s_d.irq     = s_q.reenter;
			s_d.reenter = 1'b0;
		end
	end

	// State register
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			s_q <= '{pwr_pkg::CORE_RUN, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign in_handler       = s_q.handler;
	assign powered_down     = (s_q.st != pwr_pkg::CORE_RUN) || !clk_stable;
	assign take_irq         = s_q.irq;
	assign idle_fallthrough = s_q.fall;
	assign state            = s_q.st;
endmodule // core_power_ctrl

// ### sim/pwr_monitor.sv
// Port-level assertions for the two-core power sequencer.
// Assumes one clock domain and the async active-low nrst.
`timescale 1ns/10ps
module pwr_monitor #(
	parameter int NUM_CORES = 2
) (
	input wire logic                 clock,
	input wire logic                 nrst,
	input wire logic [NUM_CORES-1:0] pu_wr,
	input wire logic [NUM_CORES-1:0] pu_wdata,
	input wire logic [NUM_CORES-1:0] pd_wr,
	input wire logic [NUM_CORES-1:0] pd_wdata,
	input wire logic                 crystal_in_use,
	input wire logic                 xtal_keep_running,
	input wire logic [NUM_CORES-1:0] power_up_request,
	input wire logic [NUM_CORES-1:0] power_down_request,
	input wire logic [NUM_CORES-1:0] pd_irq,
	input wire logic [15:0]          pd_vector,
	input wire logic [NUM_CORES-1:0] idle_fallthrough,
	input wire logic [NUM_CORES-1:0] core_clk_en,
	input wire logic                 gen_enable,
	input wire logic                 gen_stable,
	input wire logic                 osc_enable,
	input wire logic                 host_mem_grant
);
	// ==========================================
	// Properties, core 0 watched for per-core timing
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	a_vector_fixed: assert property (pd_vector == 16'h0004) else $error("bad vector");
	a_pd_irq_delay: assert property (pd_wr[0] && pd_wdata[0] && gen_stable && !power_up_request[0]
		&& !power_down_request[0] |-> ##[1:3] pd_irq[0]) else $error("no pd irq");
	a_irq_handler: assert property (pd_irq[0] |-> ##[0:1] power_up_request[0])
		else $error("handler bit low");
	a_fall_keeps: assert property (idle_fallthrough[0] |-> core_clk_en[0])
		else $error("fallthrough stopped clock");
	a_entry_gated: assert property ($rose(power_down_request[0]) && gen_stable |-> !core_clk_en[0])
		else $error("asleep with clock");
	a_unstable_down: assert property (!gen_stable [*3] |-> &power_down_request)
		else $error("down bit low while unstable");
	// Registered lag on the down bits, so demand three settled cycles
	a_gen_stops: assert property ((gen_stable && &power_down_request) [*3] |-> ##[1:3] !gen_enable)
		else $error("generator kept running");
	a_gen_restart: assert property (!gen_enable && |(pu_wr & pu_wdata & power_up_request)
		|-> ##[1:3] gen_enable) else $error("generator no restart");
	a_recover_bound: assert property ($rose(gen_enable) |-> ##[1:99] gen_stable)
		else $error("slow recovery");
	a_no_grant_off: assert property (!gen_stable |-> !host_mem_grant)
		else $error("grant while stopped");
	a_osc_kept: assert property ((!crystal_in_use || xtal_keep_running) [*2] |-> osc_enable)
		else $error("oscillator stopped");
endmodule // pwr_monitor

bind dual_core_power_control pwr_monitor #(.NUM_CORES(NUM_CORES)) u_mon (.clock(clock),
	.nrst(nrst), .pu_wr(pu_wr), .pu_wdata(pu_wdata), .pd_wr(pd_wr), .pd_wdata(pd_wdata),
	.crystal_in_use(crystal_in_use), .xtal_keep_running(xtal_keep_running),
	.power_up_request(power_up_request), .power_down_request(power_down_request),
	.pd_irq(pd_irq), .pd_vector(pd_vector), .idle_fallthrough(idle_fallthrough),
	.core_clk_en(core_clk_en), .gen_enable(gen_enable), .gen_stable(gen_stable),
	.osc_enable(osc_enable), .host_mem_grant(host_mem_grant));

// ### sim/tb.sv
// Self-checking bench for the two-core power sequencer.
// Assumes the core and host strobes are plain pulses on clock.
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin error_cnt++; \
	$display("Error %s expected %h seen %h", n, e, a); end end
module tb;
	logic        clock = 0, nrst = 0, mem_clk_stop_cfg = 1, crystal_in_use = 1;
	logic        xtal_keep_running = 0, host_mem_req = 0;
	logic [1:0]  pu_wr = 0, pu_wdata = 0, pd_wr = 0, pd_wdata = 0, ctx_select = 0;
	logic [1:0]  core_idle_exec = 0, core_rti_exec = 0;
	logic [1:0]  power_up_request, power_down_request, pd_irq, idle_fallthrough;
	logic [1:0]  core_clk_en, mem_clk_en, resume_clear_ctx;
	logic [15:0] pd_vector;
	logic        gen_enable, gen_stable, osc_enable, host_mem_grant, host_mem_refused;
	int          error_cnt = 0, checks = 0;

	// ==========================================
	// Clock and design
	initial forever #10 clock = ~clock;
	dual_core_power_control #(.NUM_CORES(2)) uut (.clock(clock), .nrst(nrst), .pu_wr(pu_wr),
		.pu_wdata(pu_wdata), .pd_wr(pd_wr), .pd_wdata(pd_wdata), .core_idle_exec(core_idle_exec),
		.core_rti_exec(core_rti_exec), .ctx_select(ctx_select), .mem_clk_stop_cfg(mem_clk_stop_cfg),
		.crystal_in_use(crystal_in_use), .xtal_keep_running(xtal_keep_running),
		.host_mem_req(host_mem_req), .power_up_request(power_up_request),
		.power_down_request(power_down_request), .pd_irq(pd_irq), .pd_vector(pd_vector),
		.idle_fallthrough(idle_fallthrough), .core_clk_en(core_clk_en), .mem_clk_en(mem_clk_en),
		.resume_clear_ctx(resume_clear_ctx), .gen_enable(gen_enable), .gen_stable(gen_stable),
		.osc_enable(osc_enable), .host_mem_grant(host_mem_grant),
		.host_mem_refused(host_mem_refused));

	// ==========================================
	// Shared tasks
	task wrap_up;
		if (error_cnt == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// One pulse: 0 down, 1 up, 2 idle, 3 return, else zero writes; then settle
	task op(input int k, input int c);
		@(posedge clock);
		case (k)
			0: begin pd_wr[c] <= 1; pd_wdata[c] <= 1; end
			1: begin pu_wr[c] <= 1; pu_wdata[c] <= 1; end
			2: core_idle_exec[c] <= 1;
			3: core_rti_exec[c] <= 1;
			default: begin pd_wr[c] <= 1; pu_wr[c] <= 1; end
		endcase
		@(posedge clock);
		{pd_wr, pd_wdata, pu_wr, pu_wdata, core_idle_exec, core_rti_exec} <= '0;
		repeat (4) @(posedge clock);
		#1;
	endtask

	// Bounded wait for a settled generator; the bound is the recovery limit
	task wgs;
		int n;
		n = 0;
		while (gen_stable !== 1'b1) begin
			@(posedge clock);
			#1;
			n++;
			if (n > 99) begin error_cnt++; wrap_up; end
		end
	endtask

	// ==========================================
	// Scenarios
	task t_idle;
		// Down bits lag the settled flag by one registered stage
		repeat (2) @(posedge clock);
		#1;
		`CHK("vector", 16'h0004, pd_vector)
		`CHK("pu_bits", 2'b00, power_up_request)
		`CHK("pd_bits", 2'b00, power_down_request)
		op(4, 0);
		`CHK("pu_zero", 2'b00, power_up_request)
		`CHK("pd_zero", 2'b00, power_down_request)
	endtask

	// Power-up before idle makes the idle fall through
	task t_abort;
		op(0, 0);
		`CHK("pu_in_handler", 2'b01, power_up_request)
		op(1, 0);
		op(2, 0);
		`CHK("clk_after_fall", 2'b11, core_clk_en)
		`CHK("pd_after_fall", 2'b00, power_down_request)
		op(3, 0);
		`CHK("pu_after_ret", 2'b00, power_up_request)
	endtask

	// Both asleep, generator stops, wake one, then wake the other and check its handler re-entry
	task t_sleep;
		@(posedge clock);
		ctx_select <= 2'b10;
		// Host asks throughout, waking included; grant is checked asleep and once settled
		host_mem_req <= 1;
		for (int c = 0; c < 2; c++) begin op(0, c); op(2, c); end
		`CHK("pd_asleep", 2'b11, power_down_request)
		`CHK("pu_asleep", 2'b11, power_up_request)
		`CHK("clk_gated", 2'b00, core_clk_en)
		`CHK("gen_off", 1'b0, gen_enable)
		`CHK("osc_off", 1'b0, osc_enable)
		`CHK("grant_off", 1'b0, host_mem_grant)
		`CHK("refused_off", 1'b1, host_mem_refused)
		`CHK("memclk_off", 2'b00, mem_clk_en)
		@(posedge clock);
		xtal_keep_running <= 1;
		repeat (3) @(posedge clock);
		#1;
		`CHK("osc_kept", 1'b1, osc_enable)
		op(0, 0);
		op(1, 1);
		wgs;
		repeat (2) @(posedge clock);
		#1;
		`CHK("gen_on", 1'b1, gen_enable)
		`CHK("pd_woke", 2'b01, power_down_request)
		`CHK("ctx_clear", 1'b1, resume_clear_ctx[1])
		`CHK("clk_woke", 1'b1, core_clk_en[1])
		`CHK("grant_on", 1'b1, host_mem_grant)
		`CHK("refused_on", 1'b0, host_mem_refused)
		op(1, 0);
		op(3, 0);
		op(3, 1);
		`CHK("pu_reenter", 2'b01, power_up_request)
	endtask

	// ==========================================
	// Main sequence
	initial begin
		// Short reset hold; the multiplier settle is modelled by the settle count
		repeat (16) @(posedge clock);
		nrst <= 1;
		wgs;
		t_idle;
		t_abort;
		t_sleep;
		wrap_up;
	end
endmodule // tb
